// ===== rtl/pie_glue.sv
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module pie_glue
#(
    parameter int UNITS = 2
)
(
    // Clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        arst_n,
    input  wire logic                        ce,
    // APB slave
    input  wire logic [pie_pkg::ADDR_W-1:0]  paddr,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Processor side
    output logic                             int_request,
    output logic                             irq,
    // Link to the array
    pie_if.host                              link
);
    import pie_pkg::*;

    generate
        if (UNITS < 1 || UNITS > MAX_UNITS)
        begin : g_bad_units
            $error("pie_glue: UNITS out of range");
        end
    endgenerate

    pie_ack_e            state;
    logic [1:0]          cnt;
    logic [CTRL_W-1:0]   ctrl;
    logic [7:0]          vector;
    logic [IRQ_W-1:0]    irq_status;
    logic [IRQ_W-1:0]    irq_mask;
    logic [UNITS-1:0]    strobe_n;
    logic [STATUS_W-1:0] data_n;
    logic                ack_status;
    logic                input_strobe;
    logic                wr;
    logic                ack_done;
    logic                int_event;
    logic [31:0]         rd_data;
    logic                rd_ok;
    logic [STATUS_UNIT_W-1:0] unit_sel;

    assign wr        = ce && psel && penable && pwrite && pready;
    assign int_event = !link.int_line_n;
    assign ack_done  = (state == PIE_ACK_GATE) && (cnt == ACK_LAST);
    assign unit_sel  = pwdata[STATUS_UNIT_LSB +: STATUS_UNIT_W];

    // Read decode
    always_comb
    begin
        rd_data = '0;
        rd_ok   = 1'b1;
        case (paddr)
            OFS_CTRL:        rd_data[CTRL_W-1:0]  = ctrl;
            OFS_STATUS_LOAD: rd_data[STATUS_W-1:0] = data_n;
            OFS_ARRAY:       rd_data[ARRAY_W-1:0] = link.array_value;
            OFS_ACK:         rd_data[0]           = (state == PIE_ACK_GATE);
            OFS_VECTOR:      rd_data[7:0]         = vector;
            OFS_IRQ_STATUS:  rd_data[IRQ_W-1:0]   = irq_status;
            OFS_IRQ_MASK:    rd_data[IRQ_W-1:0]   = irq_mask;
            default:         rd_ok                = 1'b0;
        endcase
    end

    // APB answer, ready in first access cycle
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end
        else if (ce)
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !rd_ok;
            if (psel && !penable && !pwrite)
            begin
                prdata <= rd_data;
            end
        end
    end

    // Control and mask registers
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ctrl     <= CTRL_RESET;
            irq_mask <= IRQ_RESET;
        end
        else if (wr)
        begin
            if (paddr == OFS_CTRL)
            begin
                ctrl <= pwdata[CTRL_W-1:0];
            end
            if (paddr == OFS_IRQ_MASK)
            begin
                irq_mask <= pwdata[IRQ_W-1:0];
            end
        end
    end

    // Status load onto data bus with one-cycle strobe
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            strobe_n <= '1;
            data_n   <= STATUS_RESET;
        end
        else if (ce)
        begin
            strobe_n <= '1;
            if (wr && paddr == OFS_STATUS_LOAD)
            begin
                data_n <= pwdata[STATUS_W-1:0];
                for (int i = 0; i < UNITS; i++)
                begin
                    if (unit_sel == STATUS_UNIT_W'(i))
                    begin
                        strobe_n[i] <= 1'b0;
                    end
                end
            end
        end
    end

    // Acknowledge sequence
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state <= PIE_ACK_IDLE;
            cnt   <= '0;
        end
        else if (ce)
        begin
            case (state)
                PIE_ACK_IDLE:
                begin
                    cnt <= '0;
                    if (wr && paddr == OFS_ACK && pwdata[0])
                    begin
                        state <= PIE_ACK_GATE;
                    end
                end
                PIE_ACK_GATE:
                begin
                    cnt <= cnt + 2'h1;
                    if (ack_done)
                    begin
                        state <= PIE_ACK_IDLE;
                    end
                end
                default:
                begin
                    state <= PIE_ACK_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ack_status   <= 1'b0;
            input_strobe <= 1'b0;
        end
        else if (ce)
        begin
            ack_status   <= (state == PIE_ACK_GATE) && !ack_done;
            input_strobe <= (state == PIE_ACK_GATE) && !ack_done;
        end
    end

    // Vector latch enabled by acknowledge and input strobe
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            vector <= '0;
        end
        else if (ce && ack_status && input_strobe && ack_done)
        begin
            if (ctrl[CTRL_COMMON_BIT])
            begin
                vector <= OP_RST7;
            end
            else
            begin
                vector <= OP_RST_BASE | {2'h0, ~link.level_line_n, 3'h0};
            end
        end
    end

    // Interrupt capture flop
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            int_request <= 1'b0;
        end
        else if (ce)
        begin
            if (int_event)
            begin
                int_request <= 1'b1;
            end
            else if (ack_done)
            begin
                int_request <= 1'b0;
            end
        end
    end

    // Sticky status, set wins over write-one clear
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            irq_status <= IRQ_RESET;
            irq       <= 1'b0;
        end
        else if (ce)
        begin
            for (int b = 0; b < IRQ_W; b++)
            begin
                if ((b == IRQ_INT_BIT && int_event) || (b == IRQ_ACK_BIT && ack_done))
                begin
                    irq_status[b] <= 1'b1;
                end
                else if (wr && paddr == OFS_IRQ_STATUS && pwdata[b])
                begin
                    irq_status[b] <= 1'b0;
                end
            end
            irq <= |(irq_status & irq_mask);
        end
    end

    // Outputs to the array
    assign link.vector_gate_n        = {UNITS{!ack_status}};
    assign link.status_data_n        = data_n;
    assign link.status_load_strobe_n = strobe_n;
    assign link.irq_allow            = ctrl[CTRL_ALLOW_BIT];
    assign link.chain_enable_in      = ctrl[CTRL_CHAIN_BIT];

endmodule

// ===== shared/pie_pkg.sv
package pie_pkg;

    // Array geometry
    localparam int MAX_UNITS       = 5;
    localparam int LEVELS_PER_UNIT = 8;
    localparam int CODE_W          = 3;
    localparam int STATUS_W        = 4;
    localparam int SGS_BIT         = 3;
    localparam int LEVEL_W         = 6;
    localparam int ARRAY_SHIFT     = 3;
    localparam int ARRAY_W         = LEVEL_W + ARRAY_SHIFT;

    // Device reset values
    localparam logic [3:0] STATUS_RESET = 4'hf;

    // APB register map
    localparam int         ADDR_W          = 8;
    localparam logic [7:0] OFS_CTRL        = 8'h00;
    localparam logic [7:0] OFS_STATUS_LOAD = 8'h04;
    localparam logic [7:0] OFS_ARRAY       = 8'h08;
    localparam logic [7:0] OFS_ACK         = 8'h0c;
    localparam logic [7:0] OFS_VECTOR      = 8'h10;
    localparam logic [7:0] OFS_IRQ_STATUS  = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK    = 8'h18;

    // Control register fields
    localparam int         CTRL_W          = 3;
    localparam int         CTRL_ALLOW_BIT  = 0;
    localparam int         CTRL_CHAIN_BIT  = 1;
    localparam int         CTRL_COMMON_BIT = 2;
    localparam logic [2:0] CTRL_RESET      = 3'h2;

    // Status load fields
    localparam int STATUS_UNIT_LSB = 8;
    localparam int STATUS_UNIT_W   = 3;

    // Interrupt status fields
    localparam int         IRQ_W       = 2;
    localparam int         IRQ_INT_BIT = 0;
    localparam int         IRQ_ACK_BIT = 1;
    localparam logic [1:0] IRQ_RESET   = 2'h0;

    // Restart opcodes
    localparam logic [7:0] OP_RST_BASE = 8'hc7;
    localparam logic [7:0] OP_RST7     = 8'hff;

    // Acknowledge timing
    localparam int         ACK_CYCLES = 2;
    localparam logic [1:0] ACK_LAST   = 2'h2;

    typedef enum logic [0:0] {PIE_ACK_IDLE, PIE_ACK_GATE} pie_ack_e;

endpackage

// ===== shared/pie_if.sv
`timescale 1ns/1ps
interface pie_if
    import pie_pkg::*;
#(
    parameter int UNITS = 2
);
    // Open-collector interrupt line
    logic [UNITS-1:0]          irq_oe;
    logic                      int_line_n;
    // Open-collector level code lines
    logic [CODE_W*UNITS-1:0]   level_oe;
    logic [CODE_W-1:0]         level_line_n;
    // Host-driven controls
    logic [UNITS-1:0]          vector_gate_n;
    logic [STATUS_W-1:0]       status_data_n;
    logic [UNITS-1:0]          status_load_strobe_n;
    logic                      irq_allow;
    logic                      chain_enable_in;
    // Device-driven chain and array
    logic                      chain_enable_out;
    logic [ARRAY_W-1:0]        array_value;

    // Wired-AND resolution
    assign int_line_n = ~|irq_oe;

    always_comb
    begin
        level_line_n = '1;
        for (int u = 0; u < UNITS; u++)
        begin
            level_line_n = level_line_n & ~level_oe[CODE_W*u +: CODE_W];
        end
    end

    modport device (
        input  int_line_n,
        input  vector_gate_n,
        input  status_data_n,
        input  status_load_strobe_n,
        input  irq_allow,
        input  chain_enable_in,
        output irq_oe,
        output level_oe,
        output chain_enable_out,
        output array_value
    );

    modport host (
        input  int_line_n,
        input  level_line_n,
        input  chain_enable_out,
        input  array_value,
        output vector_gate_n,
        output status_data_n,
        output status_load_strobe_n,
        output irq_allow,
        output chain_enable_in
    );

endinterface

// ===== rtl/pie_unit_array.sv
`timescale 1ns/1ps
// Contract
// - Active interrupt sets the request block flop
// - Only status load strobe clears block flop
// - Shared open-collector interrupt blocks every unit
// - Pending enabled request raises interrupt output
// - Winner encoded as three-bit level code
// - Vector latch drives only during acknowledge read
// - Glue captures short interrupt in flop
// - Software writes current level as reference
// - Status inputs come from processor data bus
// - Enable-out feeds next enable-in, first highest
// - One to five identical units, 8-40 levels
// - Common restart-7 vector for chained arrays
// - Whole array readable as one port
// - Array value low three bits zero
// - Line 7 highest, line 0 lowest
// - Interrupt only above stored level unless disabled
// - Low allow input blocks all interrupts
// - Interrupt output lasts one clock period
module pie_unit_array
#(
    parameter int UNITS = 2
)
(
    // Clock and reset
    input  wire logic                                      clk_sys,
    input  wire logic                                      arst_n,
    input  wire logic                                      ce,
    // Peripheral requests, unit 0 first
    input  wire logic [pie_pkg::LEVELS_PER_UNIT*UNITS-1:0] request_n,
    // Link to the glue
    pie_if.device                                          link
);
    import pie_pkg::*;

    generate
        if (UNITS < 1 || UNITS > MAX_UNITS)
        begin : g_bad_units
            $error("pie_unit_array: UNITS out of range");
        end
    endgenerate

    // Highest set line wins
    function automatic logic [CODE_W-1:0] top_level(input logic [LEVELS_PER_UNIT-1:0] req);
        logic [CODE_W-1:0] lvl;
        lvl = '0;
        for (int i = 0; i < LEVELS_PER_UNIT; i++)
        begin
            if (req[i])
            begin
                lvl = CODE_W'(i);
            end
        end
        return lvl;
    endfunction

    // Global level scaled to service entry
    function automatic logic [ARRAY_W-1:0] array_code(input int unit, input logic [CODE_W-1:0] lvl);
        logic [LEVEL_W-1:0] glob;
        glob = LEVEL_W'((UNITS - 1 - unit) * LEVELS_PER_UNIT) + LEVEL_W'(lvl);
        return {glob, {ARRAY_SHIFT{1'b0}}};
    endfunction

    logic [STATUS_W-1:0]        status_q [UNITS];
    logic [LEVELS_PER_UNIT-1:0] latch_q  [UNITS];
    logic [CODE_W-1:0]          win      [UNITS];
    logic [UNITS-1:0]           block_q;
    logic [UNITS-1:0]           irq_q;
    logic [UNITS-1:0]           chain_q;
    logic [UNITS-1:0]           en_in;
    logic [UNITS-1:0]           pending;
    logic [UNITS-1:0]           cmp_ok;
    logic [UNITS-1:0]           issue;
    logic [CODE_W*UNITS-1:0]    level_q;
    logic [ARRAY_W-1:0]         array_q;
    logic [ARRAY_W-1:0]         next_array;

    genvar u;
    generate
        for (u = 0; u < UNITS; u++)
        begin : g_unit
            // Chain input
            if (u == 0)
            begin : g_first
                assign en_in[u] = link.chain_enable_in;
            end
            else
            begin : g_next
                assign en_in[u] = chain_q[u-1];
            end

            // Decision logic
            always_comb
            begin
                pending[u] = |latch_q[u];
                win[u]     = top_level(latch_q[u]);
                cmp_ok[u]  = !status_q[u][SGS_BIT] ||
                             (win[u] > ~status_q[u][CODE_W-1:0]);
                issue[u]   = pending[u] && en_in[u] && link.irq_allow &&
                             cmp_ok[u] && !block_q[u] && link.int_line_n;
            end

            // Current status reference
            always_ff @(posedge clk_sys or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    status_q[u] <= STATUS_RESET;
                end
                else if (ce && !link.status_load_strobe_n[u])
                begin
                    status_q[u] <= link.status_data_n;
                end
            end

            // Request latch, closed while blocked
            always_ff @(posedge clk_sys or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    latch_q[u] <= '0;
                end
                else if (ce && (!block_q[u] || (!link.status_load_strobe_n[u] && link.int_line_n)))
                begin
                    latch_q[u] <= ~request_n[LEVELS_PER_UNIT*u +: LEVELS_PER_UNIT];
                end
            end

            // Request block flop, set wins over clear
            always_ff @(posedge clk_sys or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    block_q[u] <= 1'b0;
                end
                else if (ce)
                begin
                    if (issue[u] || !link.int_line_n)
                    begin
                        block_q[u] <= 1'b1;
                    end
                    else if (!link.status_load_strobe_n[u])
                    begin
                        block_q[u] <= 1'b0;
                    end
                end
            end

            // Interrupt pulse onto shared line
            always_ff @(posedge clk_sys or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    irq_q[u] <= 1'b0;
                end
                else if (ce)
                begin
                    irq_q[u] <= issue[u];
                end
            end

            // Chain enable toward lower unit
            always_ff @(posedge clk_sys or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    chain_q[u] <= 1'b0;
                end
                else if (ce)
                begin
                    chain_q[u] <= en_in[u] && !pending[u];
                end
            end

            // Gated open-collector level code
            always_ff @(posedge clk_sys or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    level_q[CODE_W*u +: CODE_W] <= '0;
                end
                else if (ce)
                begin
                    if (!link.vector_gate_n[u] && pending[u] && en_in[u])
                    begin
                        level_q[CODE_W*u +: CODE_W] <= win[u];
                    end
                    else
                    begin
                        level_q[CODE_W*u +: CODE_W] <= '0;
                    end
                end
            end
        end
    endgenerate

    // Array port value, unit 0 highest
    always_comb
    begin
        next_array = '0;
        for (int i = UNITS - 1; i >= 0; i--)
        begin
            if (pending[i])
            begin
                next_array = array_code(i, win[i]);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            array_q <= '0;
        end
        else if (ce)
        begin
            array_q <= next_array;
        end
    end

    // Outputs
    assign link.irq_oe           = irq_q;
    assign link.level_oe         = level_q;
    assign link.chain_enable_out = chain_q[UNITS-1];
    assign link.array_value      = array_q;

endmodule

// ===== verification/pie_monitor.sv
`timescale 1ns/1ps
module pie_monitor
#(
    parameter int UNITS = 2
)
(
    // Clock and reset
    input wire logic                             clk_sys,
    input wire logic                             arst_n,
    // Link lines
    input wire logic [UNITS-1:0]                 irq_oe,
    input wire logic                             int_line_n,
    input wire logic [pie_pkg::CODE_W*UNITS-1:0] level_oe,
    input wire logic [UNITS-1:0]                 vector_gate_n,
    input wire logic [UNITS-1:0]                 status_load_strobe_n,
    input wire logic                             irq_allow,
    input wire logic                             chain_enable_in,
    input wire logic                             chain_enable_out,
    input wire logic [pie_pkg::ARRAY_W-1:0]      array_value
);
    import pie_pkg::*;

    logic [UNITS-1:0] blocked;
    logic [3:0]       off_cnt;

    // Per-unit copy of the request block
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            blocked <= '0;
        else if (!int_line_n)
            blocked <= '1;
        else
            blocked <= blocked & status_load_strobe_n;
    end

    // Cycles with the chain enable low
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
            off_cnt <= '0;
        else if (chain_enable_in)
            off_cnt <= '0;
        else if (off_cnt != 4'hf)
            off_cnt <= off_cnt + 4'h1;
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    int_pulse_a: assert property (|irq_oe |=> ~|irq_oe)
        else $error("interrupt pulse too long");
    block_hold_a: assert property ((blocked & irq_oe) == '0)
        else $error("interrupt while blocked");
    allow_off_a: assert property (!irq_allow |=> ~|irq_oe)
        else $error("interrupt while disallowed");
    chain_first_a: assert property (irq_oe[0] |-> $past(chain_enable_in))
        else $error("interrupt without chain enable");
    chain_off_a: assert property (off_cnt >= UNITS |-> !chain_enable_out)
        else $error("chain out without chain in");
    array_low_a: assert property (array_value[ARRAY_SHIFT-1:0] == '0)
        else $error("array value low bits set");
    code_gated_a: assert property (level_oe != '0 |-> $past(vector_gate_n) != '1)
        else $error("level code without gate");
    gate_len_a: assert property ($fell(vector_gate_n[0]) |=> !vector_gate_n[0] ##1 vector_gate_n == '1)
        else $error("vector gate length wrong");
endmodule

// ===== verification/priority_interrupt_encoder_bench.sv
`timescale 1ns/1ps
module priority_interrupt_encoder_bench;
    import pie_pkg::*;

    localparam int          UNITS = 2;
    localparam int          REQ_W = 8 * UNITS;
    localparam int          LIMIT = 100;
    localparam logic [32:0] ERR   = 33'h1_0000_0000;

    logic              clk_sys   = 1'b0;
    logic              arst_n    = 1'b0;
    logic [ADDR_W-1:0] paddr     = '0;
    logic              psel      = 1'b0;
    logic              penable   = 1'b0;
    logic              pwrite    = 1'b0;
    logic [31:0]       pwdata    = '0;
    logic [REQ_W-1:0]  request_n = '1;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              int_request;
    logic              irq;
    logic [REQ_W-1:0]  r;
    logic [31:0]       rd;
    logic [32:0]       exp_q[$];
    logic [32:0]       msk_q[$];
    logic [32:0]       e;
    logic [32:0]       m;
    int                failures = 0;
    int                checks   = 0;
    int                g;
    int                seed;

    always #20 clk_sys = ~clk_sys;

    pie_if #(.UNITS(UNITS)) pie_if_i ();

    pie_unit_array #(.UNITS(UNITS)) pie_unit_array_i (.clk_sys(clk_sys), .arst_n(arst_n), .ce(1'b1),
        .request_n(request_n), .link(pie_if_i.device));

    pie_glue #(.UNITS(UNITS)) pie_glue_i (.clk_sys(clk_sys), .arst_n(arst_n), .ce(1'b1), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .int_request(int_request), .irq(irq), .link(pie_if_i.host));

    pie_monitor #(.UNITS(UNITS)) pie_monitor_i (.clk_sys(clk_sys), .arst_n(arst_n), .irq_oe(pie_if_i.irq_oe),
        .int_line_n(pie_if_i.int_line_n), .level_oe(pie_if_i.level_oe), .vector_gate_n(pie_if_i.vector_gate_n),
        .status_load_strobe_n(pie_if_i.status_load_strobe_n), .irq_allow(pie_if_i.irq_allow),
        .chain_enable_in(pie_if_i.chain_enable_in), .chain_enable_out(pie_if_i.chain_enable_out),
        .array_value(pie_if_i.array_value));

    task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] want);
        checks++;
        if (seen !== want)
        begin
            failures++;
            $display("unexpected %s expected %h seen %h", nm, want, seen);
        end
    endtask

    task automatic final_report;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // One APB transfer, held until pready
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < LIMIT);
        if (n >= LIMIT)
        begin
            check("pready", 33'h0, 33'h1);
            final_report();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rdx(input logic [7:0] a, input logic [32:0] want, input logic [32:0] mask);
        exp_q.push_back(want);
        msk_q.push_back(mask);
        apb(a, 1'b0, 32'h0);
    endtask

    // Read results against the oldest note
    always @(posedge clk_sys)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            if (m != '0)
                check("prdata", {pslverr, prdata} & m, e & m);
        end
    end

    task automatic wait_irq(input logic want);
        int n;
        n = 0;
        if (want == 1'b0)
            repeat (20) @(posedge clk_sys);
        while (irq !== want && n < 20)
        begin
            @(posedge clk_sys);
            n++;
        end
        check("irq", {32'h0, irq}, {32'h0, want});
        if (irq !== want)
            final_report();
    endtask

    task automatic load_all(input logic [3:0] sn);
        for (int u = 0; u < UNITS; u++)
            apb(OFS_STATUS_LOAD, 1'b1, (32'(u) << STATUS_UNIT_LSB) | 32'(sn));
    endtask

    // Acknowledge, vector read, clear and reload
    task automatic serve(input int lvl, input logic common);
        int n;
        n = 0;
        check("int_request", {32'h0, int_request}, 33'h1);
        rdx(OFS_ARRAY, 33'(lvl << ARRAY_SHIFT), ERR | 33'h1ff);
        rdx(OFS_IRQ_STATUS, 33'h1, ERR | 33'h1);
        apb(OFS_ACK, 1'b1, 32'h1);
        do
        begin
            exp_q.push_back('0);
            msk_q.push_back('0);
            apb(OFS_ACK, 1'b0, 32'h0);
            n++;
        end
        while (rd[0] !== 1'b0 && n < 20);
        check("busy", {32'h0, rd[0]}, 33'h0);
        if (rd[0] !== 1'b0)
            final_report();
        rdx(OFS_VECTOR, common ? 33'(OP_RST7) : 33'(OP_RST_BASE | 8'(lvl % 8) << 3), ERR | 33'hff);
        rdx(OFS_IRQ_STATUS, 33'h3, ERR | 33'h3);
        check("int_request", {32'h0, int_request}, 33'h0);
        request_n <= '1;
        apb(OFS_IRQ_STATUS, 1'b1, 32'h3);
        load_all(4'h7);
        wait_irq(1'b0);
    endtask

    function automatic logic [REQ_W-1:0] hot(input int b);
        return REQ_W'(1) << b;
    endfunction

    function automatic int winner(input logic [REQ_W-1:0] v);
        for (int u = 0; u < UNITS; u++)
            for (int l = 7; l >= 0; l--)
                if (v[8*u + l])
                    return (UNITS - 1 - u) * 8 + l;
        return 0;
    endfunction

    initial
    begin
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        seed = $urandom(70);
        rdx(OFS_CTRL, 33'(CTRL_RESET), ERR | 33'h7);
        rdx(OFS_IRQ_STATUS, 33'(IRQ_RESET), ERR | 33'h3);
        rdx(OFS_STATUS_LOAD, 33'(STATUS_RESET), ERR | 33'hf);
        rdx(OFS_ARRAY, 33'h0, ERR | 33'h1ff);
        rdx(8'h1c, ERR, ERR);
        $display("test reset done");
        apb(OFS_CTRL, 1'b1, 32'h3);
        load_all(4'ha);
        apb(OFS_IRQ_MASK, 1'b1, 32'h3);
        request_n <= ~hot(4);
        wait_irq(1'b0);
        request_n <= ~hot(5);
        wait_irq(1'b0);
        request_n <= ~hot(6);
        wait_irq(1'b1);
        rdx(OFS_IRQ_STATUS, 33'h1, ERR | 33'h1);
        wait_irq(1'b1);
        serve(14, 1'b0);
        $display("test compare done");
        apb(OFS_CTRL, 1'b1, 32'h1);
        request_n <= ~hot(11);
        wait_irq(1'b0);
        apb(OFS_CTRL, 1'b1, 32'h2);
        wait_irq(1'b0);
        apb(OFS_CTRL, 1'b1, 32'h7);
        wait_irq(1'b1);
        serve(3, 1'b1);
        $display("test gating done");
        apb(OFS_CTRL, 1'b1, 32'h3);
        request_n <= ~hot(2);
        wait_irq(1'b1);
        request_n <= ~(hot(2) | hot(7));
        serve(10, 1'b0);
        $display("test block done");
        for (int t = 0; t < 12; t++)
        begin
            r = REQ_W'($urandom_range(2**REQ_W - 1, 1));
            g = winner(r);
            apb(OFS_CTRL, 1'b1, {29'h0, t[0], 2'h3});
            request_n <= ~r;
            wait_irq(1'b1);
            serve(g, t[0]);
        end
        $display("test random done");
        final_report();
    end
endmodule
